// ---- hw/spim_core.sv ----
// Serial peripheral master with an 8-bit bus-side register port
`timescale 1ns/10ps
`default_nettype none
module spim_core
  import spim_pkg::*;
(
  // Clock and resets
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sync_reset_in,
  // Register port
  input wire logic [spim_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [spim_pkg::DAT_W-1:0] wb_dat_i,
  output logic [spim_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic wb_ack_o,
  // Status
  output logic irq_out,
  output logic transfer_in_progress,
  // Serial link
  output logic sclk_o,
  output logic mosi_o,
  output logic data_out_drive_enable_n,
  input wire logic mosi_i,
  input wire logic miso_i,
  // Slave selects
  output logic slave_select_n_0,
  output logic slave_select_n_1,
  output logic slave_select_n_2,
  output logic slave_select_n_3,
  output logic slave_select_n_4,
  output logic slave_select_n_5,
  output logic slave_select_n_6,
  output logic slave_select_n_7
);
  import spim_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    spim_state_t state;
    logic [15:0] baud;
    logic [7:0] cfg;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] ssel;
    logic [2:0] bitctl;
    logic [7:0] extra;
    logic hold;
    logic rd;
    logic [7:0] sreg;
    logic latch;
    logic [4:0] edges;
    logic [8:0] xcnt;
    logic cs_act;
    logic done;
    logic rdf;
    logic wrf;
    logic ack;
    logic [7:0] dat_o;
    logic sck;
    logic mosi;
    logic oen_n;
    logic [7:0] ss_n;
    logic tip;
    logic irq;
  } spim_core_t;

  localparam spim_core_t CORE_RST = '{
    state: SPIM_IDLE,
    baud: {RST_BAUD_HI, RST_BAUD_LO},
    cfg: RST_CFG,
    tx: 8'h00,
    rx: 8'h00,
    ssel: 8'h00,
    bitctl: RST_BITCTL,
    extra: 8'h00,
    hold: 1'b0,
    rd: 1'b0,
    sreg: 8'h00,
    latch: 1'b0,
    edges: 5'h00,
    xcnt: 9'h000,
    cs_act: 1'b0,
    done: 1'b0,
    rdf: 1'b0,
    wrf: 1'b0,
    ack: 1'b0,
    dat_o: 8'h00,
    sck: 1'b0,
    mosi: 1'b0,
    oen_n: 1'b0,
    ss_n: 8'hFF,
    tip: 1'b0,
    irq: 1'b0
  };

  spim_core_t r;
  spim_core_t n;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Outgoing bit for the current bit order and length
  function automatic logic out_bit(input logic [7:0] s,
                                   input logic [2:0] last,
                                   input logic lsbf);
    out_bit = lsbf ? s[0] : s[last];
  endfunction : out_bit

  // Shift one received bit into the low or high end
  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic b,
                                          input logic [2:0] last,
                                          input logic lsbf);
    logic [7:0] res;
    res = s;
    if (lsbf) begin
      res = s >> 1;
      res[last] = b;
    end else begin
      res = {s[6:0], b};
    end
    shift_in = res;
  endfunction : shift_in

  // ---------------------------------------------------------------------------
  // Pin input synchronisers and half-period divider
  // ---------------------------------------------------------------------------
  logic [1:0] pins_s;
  logic tick;
  logic run;

  spim_sync #(
    .W(2)
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .din({mosi_i, miso_i}),
    .dout(pins_s)
  );

  assign run = (r.state != SPIM_IDLE);

  spim_div #(
    .W(16)
  ) u_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .sync_reset_in(sync_reset_in),
    .run(run),
    .divisor(r.baud),
    .tick(tick)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  logic din;
  logic cpha;
  logic lsbf;
  logic is_latch;
  logic last_edge;
  logic [4:0] k;
  logic [4:0] total;
  logic [7:0] sh;
  logic req;

  always_comb begin
    n = r;
    n.ack = 1'b0;
    cpha = r.cfg[CFG_CPHA];
    lsbf = r.cfg[CFG_LSB_FIRST];
    // Three-wire mode samples the shared line
    din = r.cfg[CFG_BIDIR] ? pins_s[1] : pins_s[0];
    total = 5'(({2'b00, r.bitctl} + 5'd1) << 1);
    k = r.edges + 5'd1;
    is_latch = k[0] ^ cpha;
    last_edge = (k == total);
    sh = shift_in(r.sreg, is_latch ? din : r.latch, r.bitctl, lsbf);
    req = wb_cyc_i && wb_stb_i && !r.ack;

    // Bus access: one acknowledge, one clock after request
    if (req) begin
      n.ack = 1'b1;
      if (wb_we_i) begin
        unique case (wb_adr_i)
          ADDR_BAUD_LO: n.baud[7:0] = wb_dat_i;
          ADDR_BAUD_HI: n.baud[15:8] = wb_dat_i;
          ADDR_CFG: n.cfg = wb_dat_i & CFG_MASK;
          ADDR_DATA: n.tx = wb_dat_i;
          ADDR_CMD_STAT: begin
            if (wb_dat_i[CMD_CLEAR]) begin
              n.done = 1'b0;
              n.rdf = 1'b0;
              n.wrf = 1'b0;
            end
            if (wb_dat_i[CMD_START] && r.cfg[CFG_ENABLE] &&
                r.state == SPIM_IDLE) begin
              // Present first bit before the first edge
              n.state = SPIM_LEAD;
              n.sreg = r.tx;
              n.mosi = out_bit(r.tx, r.bitctl, lsbf);
              n.hold = wb_dat_i[CMD_HOLD_CS];
              n.rd = wb_dat_i[CMD_READ];
              n.cs_act = 1'b1;
              n.edges = 5'h00;
              n.tip = 1'b1;
            end
          end
          ADDR_SSEL: n.ssel = wb_dat_i;
          ADDR_BITCTL: n.bitctl = wb_dat_i[2:0];
          ADDR_EXTRA: n.extra = wb_dat_i;
          default: n.extra = r.extra;
        endcase
      end else begin
        unique case (wb_adr_i)
          ADDR_BAUD_LO: n.dat_o = r.baud[7:0];
          ADDR_BAUD_HI: n.dat_o = r.baud[15:8];
          ADDR_CFG: n.dat_o = r.cfg;
          ADDR_DATA: n.dat_o = r.rx;
          ADDR_CMD_STAT: n.dat_o = {4'h0, r.wrf, r.rdf, r.done, r.tip};
          ADDR_SSEL: n.dat_o = r.ssel;
          ADDR_BITCTL: n.dat_o = {5'h00, r.bitctl};
          ADDR_EXTRA: n.dat_o = r.extra;
          default: n.dat_o = 8'h00;
        endcase
      end
    end

    // Serial engine, advanced once per half period
    if (tick) begin
      unique case (r.state)
        SPIM_IDLE: begin
          // Hold; a start taken in this cycle must not be lost
        end
        SPIM_LEAD: begin
          // Half cycle after select here, then another half cycle before the first edge
          n.state = SPIM_XFER;
        end
        SPIM_XFER: begin
          n.sck = ~r.sck;
          n.edges = k;
          if (is_latch) begin
            n.latch = din;
          end else if (!cpha || k != 5'd1) begin
            // Shift in the latched bit, drive the next
            n.sreg = sh;
            n.mosi = out_bit(sh, r.bitctl, lsbf);
          end
          if (last_edge) begin
            // Copy finished word to the receive register
            n.rx = (cpha) ? sh : n.sreg;
            n.sreg = n.rx;
            n.state = SPIM_TRAIL;
          end
        end
        SPIM_TRAIL: begin
          n.done = 1'b1;
          n.rdf = n.rdf | r.rd;
          n.wrf = n.wrf | ~r.rd;
          if (r.hold) begin
            n.state = SPIM_IDLE;
            n.tip = 1'b0;
          end else begin
            n.cs_act = 1'b0;
            if (r.extra != 8'h00) begin
              n.state = SPIM_EXTRA;
              n.xcnt = 9'h000;
            end else if (!cpha) begin
              n.state = SPIM_GAP;
            end else begin
              n.state = SPIM_IDLE;
              n.tip = 1'b0;
            end
          end
        end
        SPIM_EXTRA: begin
          // Free clocks with select released
          n.sck = ~r.sck;
          n.xcnt = r.xcnt + 9'd1;
          if (r.xcnt + 9'd1 == {r.extra, 1'b0}) begin
            n.state = cpha ? SPIM_IDLE : SPIM_GAP;
            n.tip = ~cpha;
          end
        end
        SPIM_GAP: begin
          // Minimum select-high time for phase zero
          n.state = SPIM_IDLE;
          n.tip = 1'b0;
        end
        default: begin
          n.state = SPIM_IDLE;
          n.tip = 1'b0;
        end
      endcase
    end

    // Idle clock level follows polarity
    if (n.state == SPIM_IDLE || n.state == SPIM_LEAD ||
        n.state == SPIM_GAP) begin
      n.sck = n.cfg[CFG_CPOL];
    end

    // Pin drivers
    n.ss_n = ~(n.ssel & {NUM_SS{n.cs_act}});
    n.oen_n = n.cfg[CFG_BIDIR] & n.cfg[CFG_BIDIR_OEN];
    n.irq = n.cfg[CFG_IRQ_EN] & (n.rdf | n.wrf);

    // Synchronous reset to defaults
    if (sync_reset_in) begin
      n = CORE_RST;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Asynchronous reset to defaults
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= CORE_RST;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign wb_dat_o = r.dat_o;
  assign wb_ack_o = r.ack;
  assign irq_out = r.irq;
  assign transfer_in_progress = r.tip;
  assign sclk_o = r.sck;
  assign mosi_o = r.mosi;
  assign data_out_drive_enable_n = r.oen_n;
  assign slave_select_n_0 = r.ss_n[0];
  assign slave_select_n_1 = r.ss_n[1];
  assign slave_select_n_2 = r.ss_n[2];
  assign slave_select_n_3 = r.ss_n[3];
  assign slave_select_n_4 = r.ss_n[4];
  assign slave_select_n_5 = r.ss_n[5];
  assign slave_select_n_6 = r.ss_n[6];
  assign slave_select_n_7 = r.ss_n[7];

endmodule : spim_core
`default_nettype wire

// ---- hw/spim_pkg.sv ----
// Constants, field positions and types shared by the serial master block
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package spim_pkg;

  // Bus widths and select count
  localparam int ADR_W = 3;
  localparam int DAT_W = 8;
  localparam int NUM_SS = 8;

  // Register offsets
  localparam logic [2:0] ADDR_BAUD_LO = 3'h0;
  localparam logic [2:0] ADDR_BAUD_HI = 3'h1;
  localparam logic [2:0] ADDR_CFG = 3'h2;
  localparam logic [2:0] ADDR_DATA = 3'h3;
  localparam logic [2:0] ADDR_CMD_STAT = 3'h4;
  localparam logic [2:0] ADDR_SSEL = 3'h5;
  localparam logic [2:0] ADDR_BITCTL = 3'h6;
  localparam logic [2:0] ADDR_EXTRA = 3'h7;

  // Reset values
  localparam logic [7:0] RST_BAUD_LO = 8'h01;
  localparam logic [7:0] RST_BAUD_HI = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [2:0] RST_BITCTL = 3'h7;

  // Configuration fields
  localparam int CFG_LSB_FIRST = 0;
  localparam int CFG_CPHA = 2;
  localparam int CFG_CPOL = 3;
  localparam int CFG_BIDIR = 4;
  localparam int CFG_BIDIR_OEN = 5;
  localparam int CFG_IRQ_EN = 6;
  localparam int CFG_ENABLE = 7;
  localparam logic [7:0] CFG_MASK = 8'hFD;

  // Command fields
  localparam int CMD_START = 0;
  localparam int CMD_HOLD_CS = 1;
  localparam int CMD_READ = 2;
  localparam int CMD_CLEAR = 7;

  // Status fields
  localparam int ST_TIP = 0;
  localparam int ST_DONE = 1;
  localparam int ST_RD = 2;
  localparam int ST_WR = 3;

  // Engine states
  typedef enum logic [2:0] {
    SPIM_IDLE = 3'b000,
    SPIM_LEAD = 3'b001,
    SPIM_XFER = 3'b010,
    SPIM_TRAIL = 3'b011,
    SPIM_GAP = 3'b100,
    SPIM_EXTRA = 3'b101
  } spim_state_t;

endpackage : spim_pkg

// ---- hw/spim_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module spim_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spim_sync_t;

  spim_sync_t r;
  spim_sync_t n;

  // Second stage reads only the first
  always_comb begin
    n.s1 = din;
    n.s2 = r.s1;
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign dout = r.s2;
endmodule : spim_sync
`default_nettype wire

// ---- hw/spim_div.sv ----
// Half-period tick generator for the serial clock
`timescale 1ns/10ps
`default_nettype none
module spim_div #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sync_reset_in,
  // Control
  input wire logic run,
  input wire logic [W-1:0] divisor,
  output logic tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } spim_div_t;

  spim_div_t r;
  spim_div_t n;
  logic [W-1:0] reload;

  // Count divisor cycles per half period; zero acts as one
  always_comb begin
    reload = (divisor == '0) ? '0 : divisor - W'(1);
    n = r;
    n.tick = run && (r.cnt == '0);
    if (!run || r.cnt == '0) begin
      n.cnt = reload;
    end else begin
      n.cnt = r.cnt - W'(1);
    end
    if (sync_reset_in) begin
      n = '0;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;
endmodule : spim_div
`default_nettype wire

// ---- tb/spim_core_props.sv ----
// Concurrent checks on the serial master's bus and link ports
`timescale 1ns/10ps
`default_nettype none
module spim_core_props (
  // Clock and resets
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sync_reset_in,
  // Register port
  input wire logic [spim_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  input wire logic wb_ack_o,
  // Link
  input wire logic transfer_in_progress,
  input wire logic sclk_o,
  input wire logic slave_select_n_0
);
  import spim_pkg::*;
  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  // Fresh request, not yet answered
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Idle with no bus traffic long enough for writes to settle
  sequence s_quiet;
    (!transfer_in_progress && !wb_cyc_i) [*4];
  endsequence
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_ack_single: assert property (
    @(posedge mclk) disable iff (!reset_n) wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_follows: assert property (
    @(posedge mclk) disable iff (!reset_n || sync_reset_in)
    s_req |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_cause: assert property (
    @(posedge mclk) disable iff (!reset_n)
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without strobe and cycle");
  a_tip_start: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $rose(transfer_in_progress) |-> wb_ack_o && $past(wb_we_i)
      && $past(wb_adr_i) == ADDR_CMD_STAT)
    else $error("transfer began without a command write");
  a_sel_in_xfer: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $fell(slave_select_n_0) |-> transfer_in_progress)
    else $error("select fell outside a transfer");
  a_lead_quiet: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $rose(transfer_in_progress) |-> $stable(sclk_o))
    else $error("clock moved with select");
  a_idle_still: assert property (
    @(posedge mclk) disable iff (!reset_n || sync_reset_in)
    s_quiet |-> $stable(sclk_o))
    else $error("clock moved while idle");
  a_sync_clears: assert property (
    @(posedge mclk) disable iff (!reset_n) sync_reset_in |=>
      !transfer_in_progress && slave_select_n_0 && !wb_ack_o)
    else $error("sync reset left state behind");
  a_async_clears: assert property (
    @(posedge mclk) !reset_n |->
      slave_select_n_0 && !transfer_in_progress && !wb_ack_o)
    else $error("async reset left state behind");
endmodule : spim_core_props
`default_nettype wire

// ---- tb/spim_slave_model.sv ----
// Behavioural serial slave facing the master's link pins
`timescale 1ns/10ps
`default_nettype none
module spim_slave_model (
  // Link pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  output logic miso,
  // Mode and data
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] tx,
  output logic [7:0] got,
  output int edges,
  output int extra
);
  logic [7:0] sh = 8'h00;
  int bc = 0;
  // Start-up values
  initial begin
    miso = 1'b0;
    got = 8'h00;
    edges = 0;
    extra = 0;
  end
  // Next outgoing bit; a fresh byte follows while still selected
  task automatic drive();
    if (bc == 0) sh = tx;
    miso = sh[7];
    sh = sh << 1;
    bc = (bc + 1) % 8;
  endtask : drive
  // Selection: phase 0 shows its first bit at once
  always @(negedge ss_n) begin
    bc = 0;
    if (!cpha) drive();
  end
  // Released line no longer holds the last bit
  always @(posedge ss_n) miso = ~miso;
  // Count edges; drive or latch by phase
  always @(sclk) begin
    if (ss_n) extra++;
    else begin
      edges++;
      if ((sclk != cpol) == cpha) drive();
      else got = {got[6:0], mosi};
    end
  end
endmodule : spim_slave_model
`default_nettype wire

// ---- tb/spi_master_wishbone_test.sv ----
// Self-checking bench for the serial master block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
  err_count++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module spi_master_wishbone_test;
  import spim_pkg::*;
  logic mclk = 0, reset_n = 1, sync_reset_in = 0;
  logic [2:0] adr = 0;
  logic [7:0] dat = 0, tx = 0, stx = 0, ev;
  logic we = 0, stb = 0, cyc = 0, cpol = 0, cpha = 0, tw = 0;
  int err_count = 0, check_count = 0, sel = 0, e0, x0, edges, extra;
  logic [7:0] exp_q[$];
  wire logic [7:0] rdat, got, ssv;
  wire logic ack, irq, tip, sclk, mosi, oen_n, s_miso;
  wire logic line = oen_n ? s_miso : mosi;
  wire logic miso_in = tw ? ~s_miso : s_miso;
  wire logic ss_sel = ssv[sel[2:0]];
  // Bus clock
  always #5 mclk = ~mclk;
  spim_core uut (.mclk(mclk), .reset_n(reset_n),
    .sync_reset_in(sync_reset_in), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_stb_i(stb), .wb_cyc_i(cyc),
    .wb_ack_o(ack), .irq_out(irq), .transfer_in_progress(tip),
    .sclk_o(sclk), .mosi_o(mosi), .data_out_drive_enable_n(oen_n),
    .mosi_i(line), .miso_i(miso_in),
    .slave_select_n_0(ssv[0]), .slave_select_n_1(ssv[1]),
    .slave_select_n_2(ssv[2]), .slave_select_n_3(ssv[3]),
    .slave_select_n_4(ssv[4]), .slave_select_n_5(ssv[5]),
    .slave_select_n_6(ssv[6]), .slave_select_n_7(ssv[7]));
  spim_slave_model slave (.sclk(sclk), .mosi(mosi), .ss_n(ss_sel),
    .miso(s_miso), .cpol(cpol), .cpha(cpha), .tx(stx), .got(got),
    .edges(edges), .extra(extra));
  // Bit reversal of a byte
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int b = 0; b < 8; b++) rev[b] = v[7-b];
  endfunction : rev
  // One bus access, held until acknowledged
  task automatic wb(input logic [2:0] a, input logic [7:0] d,
                    input logic w);
    int n;
    n = 0;
    adr <= a;
    dat <= d;
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin @(posedge mclk); n++; end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask : wb
  // Read with its expected value noted
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    wb(a, 8'h00, 1'b0);
  endtask : rd
  // Configure, start and wait out one transfer
  task automatic run(input logic [7:0] c, input int n,
                     input logic [7:0] cmd);
    int k;
    k = 0;
    cpha <= c[CFG_CPHA];
    cpol <= c[CFG_CPOL];
    tx = 8'($urandom);
    stx <= 8'($urandom);
    wb(ADDR_CFG, c, 1'b1);
    wb(ADDR_BITCTL, 8'(n - 1), 1'b1);
    wb(ADDR_SSEL, 8'h01 << sel, 1'b1);
    wb(ADDR_DATA, tx, 1'b1);
    e0 = edges;
    x0 = extra;
    wb(ADDR_CMD_STAT, cmd, 1'b1);
    `CHK("select", ~(8'h01 << sel), ssv)
    while (tip !== 1'b0 && k < 2000) begin @(posedge mclk); k++; end
    if (k >= 2000) err_count++;
  endtask : run
  // Verdict and end of run
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // Read monitor: each answered read against the oldest note
  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      ev = exp_q.pop_front();
      `CHK("read", ev, rdat)
    end
  end
  // Watchdog against a hang
  initial begin
    #500000;
    err_count++;
    print_verdict();
  end
  // Main sequence
  initial begin
    reset_n <= 1'b0;
    void'($urandom(32'h32ad));
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    `CHK("idle select", 8'hff, ssv)
    `CHK("idle sclk", 1'b0, sclk)
    `CHK("idle tip", 1'b0, tip)
    // Strobe without cycle must not be answered
    stb <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("no cycle ack", 1'b0, ack)
    stb <= 1'b0;
    @(posedge mclk);
    rd(ADDR_BAUD_LO, RST_BAUD_LO);
    rd(ADDR_CFG, RST_CFG);
    rd(ADDR_BITCTL, {5'h00, RST_BITCTL});
    wb(ADDR_BAUD_LO, 8'h06, 1'b1);
    // Every mode, both bit orders, every select, read and write
    for (int i = 0; i < 8; i++) begin
      sel = i;
      run({2'b11, 2'b00, i[1], i[0], 1'b0, i[2]}, 8,
          i[0] ? 8'h05 : 8'h01);
      rd(ADDR_DATA, i[2] ? rev(stx) : stx);
      `CHK("slave data", i[2] ? rev(tx) : tx, got)
      `CHK("edges", 16, edges - e0)
      rd(ADDR_CMD_STAT, i[0] ? 8'h06 : 8'h0a);
      `CHK("irq", 1'b1, irq)
      `CHK("sclk idle", cpol, sclk)
      `CHK("released", 8'hff, ssv)
      wb(ADDR_CMD_STAT, 8'h80, 1'b1);
      `CHK("irq clear", 1'b0, irq)
    end
    // Every short length, first bit from the top of the length
    sel = 3;
    for (int n = 1; n < 8; n++) begin
      run(8'h80, n, 8'h01);
      `CHK("short", tx & ~(8'hff << n), got & ~(8'hff << n))
      `CHK("short edges", 2 * n, edges - e0)
    end
    // Select held across two transfers
    sel = 5;
    run(8'h8c, 8, 8'h07);
    `CHK("held", 8'hdf, ssv)
    run(8'h8c, 8, 8'h05);
    rd(ADDR_DATA, stx);
    `CHK("dropped", 8'hff, ssv)
    // Extra clocks after release
    wb(ADDR_EXTRA, 8'h03, 1'b1);
    run(8'h80, 8, 8'h01);
    `CHK("extra", 6, extra - x0)
    wb(ADDR_EXTRA, 8'h00, 1'b1);
    // Shared line with the driver off
    tw <= 1'b1;
    run(8'hb0, 8, 8'h05);
    `CHK("drive off", 1'b1, oen_n)
    rd(ADDR_DATA, stx);
    tw <= 1'b0;
    // Synchronous reset in mid-transfer
    wb(ADDR_CFG, 8'h80, 1'b1);
    wb(ADDR_CMD_STAT, 8'h01, 1'b1);
    repeat (5) @(posedge mclk);
    sync_reset_in <= 1'b1;
    @(posedge mclk);
    sync_reset_in <= 1'b0;
    @(posedge mclk);
    `CHK("sync select", 8'hff, ssv)
    `CHK("sync tip", 1'b0, tip)
    rd(ADDR_BAUD_LO, RST_BAUD_LO);
    // Asynchronous reset between edges
    wb(ADDR_CFG, 8'h80, 1'b1);
    wb(ADDR_SSEL, 8'h20, 1'b1);
    wb(ADDR_CMD_STAT, 8'h01, 1'b1);
    #2 reset_n <= 1'b0;
    #1;
    `CHK("async select", 8'hff, ssv)
    `CHK("async tip", 1'b0, tip)
    @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    print_verdict();
  end
endmodule : spi_master_wishbone_test
bind spim_core spim_core_props u_props (.mclk(mclk), .reset_n(reset_n),
  .sync_reset_in(sync_reset_in), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
  .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
  .transfer_in_progress(transfer_in_progress), .sclk_o(sclk_o),
  .slave_select_n_0(slave_select_n_0));
`default_nettype wire
